// ==== sync_check_regs.vh ====
// Purpose: constants for the reclose synchronism-check supervisor
// Assumes: included by bare name; all numbers in one place
// Notes: voltages in 0.1 V units, angle in 0.1 degree, slip in 0.01 Hz
// Behaviour
// RQ1: A yes/no setting turns synchronism check use on or off.
// RQ2: Supervision applies to three-pole reclose attempts, any or all of them.
// RQ3: Side selector places three-phase voltage; reference comes from opposite side.
// RQ4: Six-way phase selector picks voltage for angle and magnitude checks.
// RQ5: Offer live-bus/dead-line, dead-bus/live-line and dead-bus/dead-line modes.
// RQ6: Four thresholds set live and dead levels for bus and line, 0.1-130 V.
// RQ7: Angle and slip checks operate only while both voltages are live.
// RQ8: Permission needs angle difference within closing limit, 0 to 75 degrees.
// RQ9: Permission needs slip frequency below limit, 0.1 to 5 Hz.
// RQ10: Hold timer 1-100 s bounds sync wait; expiry demands lockout.
// RQ11: Measure magnitude difference; yes/no setting enables difference supervision.
// RQ12: Enabled difference above 0.1-30 V limit blocks reclosing despite angle.
// RQ13: One permission output feeds recloser and may drive external contacts.
// RQ14: Single-pole scheme, 1P or mixed type, single-phase trip: four 1P attempts.
// RQ15: Three-pole type under 3P scheme, or mixed type, three-phase trip: four 3P attempts.
// RQ16: Lockout for listed type, scheme and trip combinations instead of reclosing.
// RQ17: Disabled check keeps permission high; enabled needs all enabled criteria.
// RQ18: Live means at or above live level; dead means at or below dead level.
`ifndef SYNC_CHECK_REGS_VH
`define SYNC_CHECK_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_BUS_LIVE 8'h04
`define OFS_BUS_DEAD 8'h08
`define OFS_LINE_LIVE 8'h0c
`define OFS_LINE_DEAD 8'h10
`define OFS_ANGLE_LIM 8'h14
`define OFS_SLIP_LIM 8'h18
`define OFS_HOLD_SEC 8'h1c
`define OFS_DIFF_LIM 8'h20
`define OFS_STATUS 8'h24
`define OFS_MEAS_DIFF 8'h28

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTL_SYNC_EN 0
`define CTL_SIDE 1
`define CTL_PHASE_LO 2
`define CTL_PHASE_HI 4
`define CTL_LBDL 5
`define CTL_DBLL 6
`define CTL_DBDL 7
`define CTL_DIFF_EN 8
`define CTL_SCHEME_LO 9
`define CTL_SCHEME_HI 10
`define CTL_TYPE_LO 11
`define CTL_TYPE_HI 12
`define CTL_SYNC_CLOSE 13

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define SCHEME_THREE_POLE 2'h0
`define SCHEME_SINGLE_POLE 2'h1
`define SCHEME_SINGLE_POLE_ZONE2 2'h2
`define TYPE_SINGLE_POLE 2'h0
`define TYPE_THREE_POLE 2'h1
`define TYPE_MIXED_POLE 2'h2
`define PROG_LOCKOUT 2'h0
`define PROG_SINGLE_DELAYS 2'h1
`define PROG_THREE_DELAYS 2'h2
`define MAX_ATTEMPTS 3'h4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RST_CONTROL 14'h0000
`define RST_BUS_LIVE 16'h0258
`define RST_BUS_DEAD 16'h0064
`define RST_LINE_LIVE 16'h0258
`define RST_LINE_DEAD 16'h0064
`define RST_ANGLE_LIM 16'h00c8
`define RST_SLIP_LIM 16'h0064
`define RST_HOLD_SEC 7'h0a
`define RST_DIFF_LIM 16'h0064
`define MIN_VOLT 16'h0001
`define MAX_VOLT 16'h0514
`define MAX_ANGLE 16'h02ee
`define MIN_SLIP 16'h000a
`define MAX_SLIP 16'h01f4
`define MIN_HOLD 16'h0001
`define MAX_HOLD 16'h0064
`define MAX_DIFF 16'h012c
`define CLK_HZ 250000000

`endif

// ==== phase_voltage_pick.v ====
// Purpose: pick reference phase and apply side placement
// Assumes: magnitudes and angles arrive registered from the front end
// Notes: registered outputs, one cycle of latency
`timescale 1ns/10ps
`include "sync_check_regs.vh"
module phase_voltage_pick #(
	parameter W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire [2:0] reference_phase_select,
	input wire three_phase_side_select,
	input wire [6*W-1:0] three_phase_mag,
	input wire [W-1:0] single_phase_mag,
	output reg [W-1:0] bus_mag_r,
	output reg [W-1:0] line_mag_r
);

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	reg [W-1:0] picked;

	// Six choices, out of range falls back to phase A
	always @* begin
		picked = three_phase_mag[W-1:0]; // [RQ4]
		if (reference_phase_select < 3'h6)
			picked = three_phase_mag[reference_phase_select*W +: W]; // [RQ4]
	end

	// Side select 1 means three-phase sits on the line side
	always @(posedge aclk) begin
		if (!aresetn) begin
			bus_mag_r <= {W{1'b0}};
			line_mag_r <= {W{1'b0}};
		end else if (three_phase_side_select) begin
			line_mag_r <= picked; // [RQ3]
			bus_mag_r <= single_phase_mag; // [RQ3]
		end else begin
			bus_mag_r <= picked; // [RQ3]
			line_mag_r <= single_phase_mag; // [RQ3]
		end
	end
endmodule

// ==== hold_timer.v ====
// Purpose: seconds-resolution wait bound for the sync criteria
// Assumes: waiting is a level held while waiting
// Notes: expired is a one-cycle pulse
`timescale 1ns/10ps
`include "sync_check_regs.vh"
module hold_timer #(
	parameter TICKS_PER_SEC = `CLK_HZ
) (
	input wire aclk,
	input wire aresetn,
	input wire waiting,
	input wire [6:0] seconds,
	output reg expired_r
);

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	reg [31:0] tick_r;
	reg [6:0] sec_r;

	// Restart whenever the wait drops, so each wait gets the full time
	always @(posedge aclk) begin
		if (!aresetn || !waiting) begin
			tick_r <= 32'h0;
			sec_r <= 7'h0;
			expired_r <= 1'b0;
		end else begin
			expired_r <= 1'b0;
			if (tick_r == TICKS_PER_SEC - 1) begin
				tick_r <= 32'h0;
				sec_r <= sec_r + 7'h1;
				if (sec_r + 7'h1 == seconds)
					expired_r <= 1'b1; // [RQ10]
			end else begin
				tick_r <= tick_r + 32'h1;
			end
		end
	end
endmodule

// ==== reclose_sync_check_supervisor.v ====
// Purpose: grant or withhold reclose permission and choose reclose program
// Assumes: AXI4-Lite slave, magnitudes in 0.1 V, angle 0.1 deg, slip 0.01 Hz
// Notes: all outputs registered; reads answer one cycle after taking, writes two cycles after taking
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "sync_check_regs.vh"
module reclose_sync_check_supervisor #(
	parameter W = 16,
	parameter TICKS_PER_SEC = `CLK_HZ
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [6*W-1:0] three_phase_mag,
	input wire [W-1:0] single_phase_mag,
	input wire [W-1:0] angle_diff,
	input wire [W-1:0] slip_freq,
	input wire reclose_request,
	input wire three_phase_trip,
	output reg close_permit_r,
	output reg lockout_demand_r,
	output reg [1:0] program_r,
	output reg [2:0] attempt_limit_r
);

	// ----------------------------------------------------------------
	// Settings registers
	// ----------------------------------------------------------------
	reg [13:0] ctl_r;
	reg [W-1:0] bus_live_r, bus_dead_r, line_live_r, line_dead_r;
	reg [W-1:0] angle_lim_r, slip_lim_r, diff_lim_r;
	reg [6:0] hold_r;
	reg [W-1:0] diff_r;
	reg [31:0] wdata_r;
	reg [7:0] awaddr_r;
	reg aw_have_r, w_have_r;
	reg waiting_r;
	wire [W-1:0] bus_mag, line_mag;
	wire expired;
	wire sync_ok;

	// Clamp a written value into its documented range
	function [W-1:0] clamp;
		input [W-1:0] v;
		input [W-1:0] lo;
		input [W-1:0] hi;
		begin
			clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	// Hold seconds fit in seven bits once clamped, so the cut loses nothing
	wire [W-1:0] hold_clamped = clamp(wdata_r[W-1:0], `MIN_HOLD, `MAX_HOLD);

	phase_voltage_pick #(.W(W)) pick_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.reference_phase_select(ctl_r[`CTL_PHASE_HI:`CTL_PHASE_LO]),
		.three_phase_side_select(ctl_r[`CTL_SIDE]),
		.three_phase_mag(three_phase_mag),
		.single_phase_mag(single_phase_mag),
		.bus_mag_r(bus_mag),
		.line_mag_r(line_mag)
	);

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	// Address and data latched separately, so either may arrive first
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 8'h0;
			wdata_r <= 32'h0;
			ctl_r <= `RST_CONTROL;
			bus_live_r <= `RST_BUS_LIVE;
			bus_dead_r <= `RST_BUS_DEAD;
			line_live_r <= `RST_LINE_LIVE;
			line_dead_r <= `RST_LINE_DEAD;
			angle_lim_r <= `RST_ANGLE_LIM;
			slip_lim_r <= `RST_SLIP_LIM;
			hold_r <= `RST_HOLD_SEC;
			diff_lim_r <= `RST_DIFF_LIM;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
				aw_have_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				w_have_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_r && w_have_r && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (awaddr_r)
				`OFS_CONTROL: ctl_r <= wdata_r[13:0]; // [RQ1] [RQ5] [RQ11]
				`OFS_BUS_LIVE: bus_live_r <= clamp(wdata_r[W-1:0], `MIN_VOLT, `MAX_VOLT); // [RQ6]
				`OFS_BUS_DEAD: bus_dead_r <= clamp(wdata_r[W-1:0], `MIN_VOLT, `MAX_VOLT); // [RQ6]
				`OFS_LINE_LIVE: line_live_r <= clamp(wdata_r[W-1:0], `MIN_VOLT, `MAX_VOLT); // [RQ6]
				`OFS_LINE_DEAD: line_dead_r <= clamp(wdata_r[W-1:0], `MIN_VOLT, `MAX_VOLT); // [RQ6]
				`OFS_ANGLE_LIM: angle_lim_r <= clamp(wdata_r[W-1:0], 16'h0, `MAX_ANGLE); // [RQ8]
				`OFS_SLIP_LIM: slip_lim_r <= clamp(wdata_r[W-1:0], `MIN_SLIP, `MAX_SLIP); // [RQ9]
				`OFS_HOLD_SEC: hold_r <= hold_clamped[6:0]; // [RQ10]
				`OFS_DIFF_LIM: diff_lim_r <= clamp(wdata_r[W-1:0], `MIN_VOLT, `MAX_DIFF); // [RQ12]
				`OFS_STATUS, `OFS_MEAS_DIFF: s_axi_bresp <= 2'h0; // Read-only, write ignored
				default: s_axi_bresp <= 2'h2; // Unmapped
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	// Read data registered; status shows live criteria state
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`OFS_CONTROL: s_axi_rdata <= {18'h0, ctl_r};
			`OFS_BUS_LIVE: s_axi_rdata <= {16'h0, bus_live_r};
			`OFS_BUS_DEAD: s_axi_rdata <= {16'h0, bus_dead_r};
			`OFS_LINE_LIVE: s_axi_rdata <= {16'h0, line_live_r};
			`OFS_LINE_DEAD: s_axi_rdata <= {16'h0, line_dead_r};
			`OFS_ANGLE_LIM: s_axi_rdata <= {16'h0, angle_lim_r};
			`OFS_SLIP_LIM: s_axi_rdata <= {16'h0, slip_lim_r};
			`OFS_HOLD_SEC: s_axi_rdata <= {25'h0, hold_r};
			`OFS_DIFF_LIM: s_axi_rdata <= {16'h0, diff_lim_r};
			`OFS_STATUS: s_axi_rdata <= {23'h0, attempt_limit_r, program_r,
				lockout_demand_r, close_permit_r, waiting_r, sync_ok};
			`OFS_MEAS_DIFF: s_axi_rdata <= {16'h0, diff_r}; // [RQ11]
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Voltage criteria
	// ----------------------------------------------------------------
	wire bus_live = bus_mag >= bus_live_r; // [RQ18]
	wire line_live = line_mag >= line_live_r; // [RQ18]
	wire bus_dead = bus_mag <= bus_dead_r; // [RQ18]
	wire line_dead = line_mag <= line_dead_r; // [RQ18]
	// Angle and slip are only meaningful with both sides energised
	wire both_live = bus_live && line_live; // [RQ7]
	wire angle_ok = angle_diff <= angle_lim_r; // [RQ8]
	wire slip_ok = slip_freq < slip_lim_r; // [RQ9]
	wire diff_ok = !ctl_r[`CTL_DIFF_EN] || (diff_r <= diff_lim_r); // [RQ12]
	assign sync_ok = both_live && angle_ok && slip_ok && diff_ok; // [RQ7] [RQ17]
	wire volt_ok = (ctl_r[`CTL_LBDL] && bus_live && line_dead) ||
		(ctl_r[`CTL_DBLL] && bus_dead && line_live) ||
		(ctl_r[`CTL_DBDL] && bus_dead && line_dead); // [RQ5] [RQ18]
	// Sync close bit off means only dead-side modes may grant
	wire any_ok = (ctl_r[`CTL_SYNC_CLOSE] && sync_ok) || volt_ok;

	// Magnitude difference, absolute
	always @(posedge aclk) begin
		if (!aresetn)
			diff_r <= {W{1'b0}};
		else
			diff_r <= (bus_mag > line_mag) ? bus_mag - line_mag : line_mag - bus_mag; // [RQ11]
	end

	hold_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) hold_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.waiting(waiting_r),
		.seconds(hold_r),
		.expired_r(expired)
	);

	// ----------------------------------------------------------------
	// Permission and lockout
	// ----------------------------------------------------------------
	// Hold wait and lockout apply to three-pole attempts only; single-pole still waits on permission
	always @(posedge aclk) begin
		if (!aresetn) begin
			close_permit_r <= 1'b1;
			lockout_demand_r <= 1'b0;
			waiting_r <= 1'b0;
		end else if (!ctl_r[`CTL_SYNC_EN]) begin
			close_permit_r <= 1'b1; // [RQ1] [RQ17]
			lockout_demand_r <= 1'b0;
			waiting_r <= 1'b0;
		end else begin
			close_permit_r <= any_ok; // [RQ13] [RQ17]
			waiting_r <= reclose_request && three_phase_trip && !any_ok; // [RQ2]
			lockout_demand_r <= expired && waiting_r; // [RQ10]
		end
	end

	// ----------------------------------------------------------------
	// Reclose program selection
	// ----------------------------------------------------------------
	wire [1:0] scheme = ctl_r[`CTL_SCHEME_HI:`CTL_SCHEME_LO];
	wire [1:0] rtype = ctl_r[`CTL_TYPE_HI:`CTL_TYPE_LO];
	wire single_scheme = scheme == `SCHEME_SINGLE_POLE || scheme == `SCHEME_SINGLE_POLE_ZONE2;
	reg [1:0] prog_nxt;

	// Unlisted combinations fall to lockout as the safe choice
	always @* begin
		prog_nxt = `PROG_LOCKOUT; // [RQ16]
		case (rtype)
		`TYPE_SINGLE_POLE:
			if (single_scheme && !three_phase_trip)
				prog_nxt = `PROG_SINGLE_DELAYS; // [RQ14]
		`TYPE_THREE_POLE:
			if (scheme == `SCHEME_THREE_POLE)
				prog_nxt = `PROG_THREE_DELAYS; // [RQ15]
		`TYPE_MIXED_POLE:
			prog_nxt = three_phase_trip ? `PROG_THREE_DELAYS : `PROG_SINGLE_DELAYS; // [RQ14] [RQ15]
		default:
			prog_nxt = `PROG_LOCKOUT;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			program_r <= `PROG_LOCKOUT;
			attempt_limit_r <= 3'h0;
		end else begin
			program_r <= prog_nxt;
			attempt_limit_r <= (prog_nxt == `PROG_LOCKOUT) ? 3'h0 : `MAX_ATTEMPTS; // [RQ14] [RQ15]
		end
	end
endmodule

// ==== sync_supervisor_properties.sv ====
// Purpose: port checks on the reclose supervisor
// Assumes: control written with address and data in one beat
// Notes: control image is rebuilt from bus writes
`timescale 1ns/10ps
`include "sync_check_regs.vh"
module sync_supervisor_props (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire reclose_request,
	input wire three_phase_trip,
	input wire close_permit_r,
	input wire lockout_demand_r,
	input wire [1:0] program_r,
	input wire [2:0] attempt_limit_r
);
	reg [13:0] ctl_r;
	reg trip_r;
	reg [1:0] quiet_r;
	wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ctl_wr = aw_w && s_axi_awaddr == `OFS_CONTROL;
	wire [1:0] typ = ctl_r[12:11];
	wire [1:0] sch = ctl_r[10:9];
	wire calm = quiet_r == 2'h3;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Quiet count gives the registered outputs time to follow a change
	always @(posedge aclk) begin
		trip_r <= three_phase_trip;
		if (!aresetn) begin
			ctl_r <= 14'h0;
			quiet_r <= 2'h0;
		end else begin
			if (ctl_wr)
				ctl_r <= s_axi_wdata[13:0];
			if (ctl_wr || three_phase_trip != trip_r)
				quiet_r <= 2'h0;
			else if (!calm)
				quiet_r <= quiet_r + 2'h1;
		end
	end

	// ----
	// Properties
	// ----
	attempt_pair_a: assert property (attempt_limit_r ==
		(program_r != `PROG_LOCKOUT ? `MAX_ATTEMPTS : 3'h0)) else $error("attempt limit off");
	lockout_pulse_a: assert property (lockout_demand_r |=> !lockout_demand_r)
		else $error("lockout pulse too long");
	lockout_cause_a: assert property ($rose(lockout_demand_r) |->
		$past(reclose_request) && $past(three_phase_trip)) else $error("lockout without wait");
	check_off_a: assert property (calm && !ctl_r[0] |-> close_permit_r)
		else $error("permit low with check off");
	none_enabled_a: assert property (calm && ctl_r[0] && !ctl_r[13] &&
		ctl_r[7:5] == 3'h0 |-> !close_permit_r) else $error("permit with nothing enabled");
	mixed_prog_a: assert property (calm && typ == `TYPE_MIXED_POLE |->
		program_r == (three_phase_trip ? `PROG_THREE_DELAYS : `PROG_SINGLE_DELAYS))
		else $error("mixed type program off");
	bad_combo_a: assert property (calm && (typ == `TYPE_THREE_POLE && sch != 2'h0 ||
		typ == `TYPE_SINGLE_POLE && (sch == 2'h0 || three_phase_trip)) |->
		program_r == `PROG_LOCKOUT) else $error("no lockout program");
	b_answer_a: assert property (aw_w |-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule

bind reclose_sync_check_supervisor sync_supervisor_props u_props (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.reclose_request(reclose_request), .three_phase_trip(three_phase_trip),
	.close_permit_r(close_permit_r), .lockout_demand_r(lockout_demand_r),
	.program_r(program_r), .attempt_limit_r(attempt_limit_r));

// ==== recloser_model.sv ====
// Purpose: stand-in for the recloser state machine
// Assumes: start is a one-cycle pulse from the bench
// Notes: closes on the first permitted cycle, else waits for lockout
`timescale 1ns/10ps
module recloser_model (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire close_permit_r,
	input wire lockout_demand_r,
	output reg reclose_request,
	output reg closed_r,
	output reg locked_r
);
	// Request held until permission or lockout ends the wait
	always @(posedge aclk) begin
		if (!aresetn || start) begin
			reclose_request <= aresetn && start;
			closed_r <= 1'b0;
			locked_r <= 1'b0;
		end else if (reclose_request && lockout_demand_r) begin
			reclose_request <= 1'b0;
			locked_r <= 1'b1;
		end else if (reclose_request && close_permit_r) begin
			reclose_request <= 1'b0;
			closed_r <= 1'b1;
		end
	end
endmodule

// ==== reclose_sync_check_supervisor_tb.sv ====
// Purpose: self-checking bench for the reclose supervisor
// Assumes: one second shortened to ten clocks
// Notes: three-phase side on bus unless a scenario says otherwise
`timescale 1ns/10ps
`include "sync_check_regs.vh"
module reclose_sync_check_supervisor_tb;
	localparam TPS = 10;
	localparam [31:0] SYNC = (1 << `CTL_SYNC_EN) | (1 << `CTL_SYNC_CLOSE);
	reg aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	reg arvalid = 1'b0, rready = 1'b0, trip = 1'b0, start = 1'b0;
	reg [7:0] awaddr = 8'h0, araddr = 8'h0;
	reg [31:0] wdata = 32'h0, rd_d;
	reg [95:0] tpm = 96'h0;
	reg [15:0] spm = 16'h0, ang = 16'h0, slp = 16'h0;
	wire awready, wready, bvalid, arready, rvalid, permit, lockout, req, closed, locked;
	wire [1:0] bresp, rresp, prog;
	wire [31:0] rdata;
	wire [2:0] att;
	reg [1:0] resp;
	integer n_mismatch = 0, total_checks = 0, n;

	reclose_sync_check_supervisor #(.TICKS_PER_SEC(TPS)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .three_phase_mag(tpm),
		.single_phase_mag(spm), .angle_diff(ang), .slip_freq(slp), .reclose_request(req),
		.three_phase_trip(trip), .close_permit_r(permit), .lockout_demand_r(lockout),
		.program_r(prog), .attempt_limit_r(att));
	recloser_model u_rec (.aclk(aclk), .aresetn(aresetn), .start(start),
		.close_permit_r(permit), .lockout_demand_r(lockout), .reclose_request(req),
		.closed_r(closed), .locked_r(locked));

	// Clock, 4 ns period
	initial begin
		forever #2 aclk = ~aclk;
	end

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Bus write; the leading edge keeps bready from two assignments at once
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do begin
				@(posedge aclk);
				if (awready === 1'b1)
					awvalid <= 1'b0;
				if (wready === 1'b1)
					wvalid <= 1'b0;
			end while (bvalid !== 1'b1);
			resp = bresp;
			bready <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do begin
				@(posedge aclk);
				if (arready === 1'b1)
					arvalid <= 1'b0;
			end while (rvalid !== 1'b1);
			rd_d = rdata;
			resp = rresp;
			rready <= 1'b0;
		end
	endtask
	task rc(input [7:0] a, input [15:0] e);
		begin
			rd(a);
			chk(rd_d, {16'h0, e});
		end
	endtask
	task setm(input [15:0] t, input [15:0] s, input [15:0] an, input [15:0] sl);
		begin
			@(posedge aclk);
			tpm <= {6{t}};
			spm <= s;
			ang <= an;
			slp <= sl;
		end
	endtask
	// Permission is a few registers deep, so wait before looking
	task pm(input e);
		begin
			repeat (6) @(posedge aclk);
			chk({31'h0, permit}, {31'h0, e});
		end
	endtask

	// ----
	// Scenarios
	// ----
	task t_regs;
		begin
			rc(`OFS_BUS_LIVE, `RST_BUS_LIVE);
			rc(`OFS_LINE_DEAD, `RST_LINE_DEAD);
			rc(`OFS_ANGLE_LIM, `RST_ANGLE_LIM);
			rc(`OFS_SLIP_LIM, `RST_SLIP_LIM);
			rc(`OFS_DIFF_LIM, `RST_DIFF_LIM);
			rd(8'h40);
			chk({rd_d[31:2], resp}, 32'h2);
			wr(8'h40, 32'h1);
			chk({30'h0, resp}, 32'h2);
		end
	endtask
	task t_sync;
		begin
			setm(16'h0, 16'h0, 16'h3e8, 16'h3e8);
			pm(1'b1);
			wr(`OFS_CONTROL, 32'h1);
			pm(1'b0);
			wr(`OFS_CONTROL, SYNC);
			setm(`RST_BUS_LIVE, `RST_LINE_LIVE, `RST_ANGLE_LIM - 16'h1, `RST_SLIP_LIM - 16'h1);
			pm(1'b1);
			setm(16'h300, 16'h300, `RST_ANGLE_LIM + 16'h1, 16'h0);
			pm(1'b0);
			setm(16'h300, 16'h300, 16'h0, `RST_SLIP_LIM);
			pm(1'b0);
			setm(16'h300, `RST_LINE_LIVE - 16'h1, 16'h0, 16'h0);
			pm(1'b0);
			setm(16'h300, 16'h301 + `RST_DIFF_LIM, 16'h0, 16'h0);
			pm(1'b1);
			wr(`OFS_CONTROL, SYNC | (1 << `CTL_DIFF_EN));
			pm(1'b0);
			setm(16'h300, 16'h300 + `RST_DIFF_LIM, 16'h0, 16'h0);
			pm(1'b1);
			rc(`OFS_MEAS_DIFF, `RST_DIFF_LIM);
		end
	endtask
	// Each mode at its exact thresholds, then one dead side one step past its level
	task t_modes;
		integer m;
		reg [15:0] b, l;
		begin
			for (m = 0; m < 3; m = m + 1) begin
				b = (m == 0) ? `RST_BUS_LIVE : `RST_BUS_DEAD;
				l = (m == 1) ? `RST_LINE_LIVE : `RST_LINE_DEAD;
				wr(`OFS_CONTROL, 32'h1 | (32'h20 << m));
				setm(b, l, 16'h3e8, 16'h3e8);
				pm(1'b1);
				setm(b + (m == 1), l + (m != 1), 16'h3e8, 16'h3e8);
				pm(1'b0);
			end
		end
	endtask
	// Only the selected slot is live; the side bit decides which mode fits
	task t_phase;
		integer p, s;
		begin
			for (s = 0; s < 2; s = s + 1)
				for (p = 0; p < 6; p = p + 1) begin
					wr(`OFS_CONTROL, (32'h20 << s) | (p << 2) | (s << 1) | 32'h1);
					tpm <= 96'h300 << (16 * p);
					spm <= 16'h0;
					pm(1'b1);
				end
		end
	endtask
	task t_program;
		integer c, k, y, t;
		reg [1:0] e;
		begin
			for (c = 0; c < 18; c = c + 1) begin
				k = c / 6;
				y = (c / 2) % 3;
				t = c % 2;
				e = (y == 2) ? (t ? `PROG_THREE_DELAYS : `PROG_SINGLE_DELAYS) :
					(y == 1) ? (k == 0 ? `PROG_THREE_DELAYS : `PROG_LOCKOUT) :
					(k != 0 && t == 0) ? `PROG_SINGLE_DELAYS : `PROG_LOCKOUT;
				wr(`OFS_CONTROL, (k << 9) | (y << 11));
				trip <= t;
				repeat (4) @(posedge aclk);
				chk({30'h0, prog}, {30'h0, e});
				chk({29'h0, att}, (e != 0) ? {29'h0, `MAX_ATTEMPTS} : 32'h0);
			end
		end
	endtask
	// Recloser waits on a bad angle until the hold time runs out
	task t_hold(input [15:0] an, input ok);
		begin
			setm(16'h300, 16'h300, an, 16'h0);
			trip <= 1'b1;
			repeat (6) @(posedge aclk);
			start <= 1'b1;
			@(posedge aclk);
			start <= 1'b0;
			// Let the model clear its old closed/locked flags before looking
			@(posedge aclk);
			n = 0;
			while (locked !== 1'b1 && closed !== 1'b1 && n < 100) begin
				@(posedge aclk);
				n = n + 1;
			end
			chk({31'h0, closed}, {31'h0, ok});
			chk({31'h0, ok || n >= 2 * TPS && n <= 2 * TPS + 8}, 32'h1);
		end
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_sync;
		t_modes;
		t_phase;
		t_program;
		wr(`OFS_HOLD_SEC, 32'h2);
		wr(`OFS_CONTROL, SYNC);
		t_hold(16'h3e8, 1'b0);
		t_hold(16'h0, 1'b1);
		wr(`OFS_BUS_LIVE, 32'h0);
		rc(`OFS_BUS_LIVE, `MIN_VOLT);
		wr(`OFS_ANGLE_LIM, 32'hffff);
		rc(`OFS_ANGLE_LIM, `MAX_ANGLE);
		finish_test;
	end
	// Watchdog; the run needs well under ten thousand cycles
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		finish_test;
	end
endmodule
